// File: hdl/wdhw_top.sv
`timescale 1ns/1ps
// Watchdog with halt entry and wake-up control
module wdhw_top import wdhw_pkg::*; #(
  parameter int PA_W = WDHW_PORTA_W,
  parameter int IRQ_W = WDHW_IRQ_W,
  parameter int PRE_W = WDHW_PRE_W,
  parameter int CNT_W = WDHW_CNT_W
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Core instruction strobes
  input wire logic halt_i,
  input wire logic single_dog_clear_i,
  input wire logic first_half_dog_clear_i,
  input wire logic second_half_dog_clear_i,
  input wire logic [IRQ_W-1:0] irq_req_i,
  input wire logic [IRQ_W-1:0] irq_en_i,
  input wire logic stack_full_i,
  // Pins and oscillators
  input wire logic external_reset_pin_n_i,
  input wire logic [PA_W-1:0] porta_i,
  input wire logic wdt_osc_i,
  input wire logic rtc_osc_i,
  // Results to the core
  output logic sys_clk_en_o,
  output logic osc32k_en_o,
  output logic hold_ports_o,
  output logic device_reset_o,
  output logic pc_sp_reset_o,
  output logic resume_next_o,
  output logic irq_take_o,
  output logic power_down_flag_o,
  output logic timeout_flag_o
);
  generate
    if (PA_W < 1 || PA_W > 32 || IRQ_W < 1) begin : g_chk
      $error("wdhw_top port widths out of range");
    end
  endgenerate

  localparam int ST_W = $clog2(WDHW_STARTUP_CYC);
  localparam logic [ST_W-1:0] ST_LAST = ST_W'(WDHW_STARTUP_CYC - 1);
  localparam int DV_W = $clog2(WDHW_INS_DIV);
  localparam logic [DV_W-1:0] DV_LAST = DV_W'(WDHW_INS_DIV - 1);

  typedef enum logic [2:0] {
    WDHW_RUN = 3'h1,
    WDHW_DOWN = 3'h2,
    WDHW_START = 3'h4
  } wdhw_state_t;

  typedef enum logic [1:0] {
    WDHW_WK_NONE = 2'h0,
    WDHW_WK_NEXT = 2'h1,
    WDHW_WK_IRQ = 2'h2
  } wdhw_wake_t;

  // Rising edge of a synchronised level
  function automatic logic rise(input logic prev, input logic cur);
    rise = cur && !prev;
  endfunction

  // Two-stage synchronisers for all pins
  localparam int SY_W = PA_W + 3;
  logic [SY_W-1:0] sync_a;
  logic [SY_W-1:0] sync_b;
  logic osc_prev;
  logic rtc_prev;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sync_a <= {SY_W{1'b1}};
      sync_b <= {SY_W{1'b1}};
    end else if (ce_i) begin
      sync_a <= {porta_i, external_reset_pin_n_i, wdt_osc_i, rtc_osc_i};
      sync_b <= sync_a;
    end
  end
  wire [PA_W-1:0] pa_s = sync_b[SY_W-1:3];
  wire pin_rst = !sync_b[2];
  wire osc_s = sync_b[1];
  wire rtc_s = sync_b[0];
  wire osc_edge = rise(osc_prev, osc_s);
  wire rtc_edge = rise(rtc_prev, rtc_s);

  // Registers and state
  logic dog_en;
  logic [1:0] src;
  logic pair_mode;
  logic idle_select_bit;
  logic [PA_W-1:0] wake_en;
  logic power_down_flag;
  logic tof;
  wdhw_state_t state;
  wdhw_half_t last_half;
  wdhw_wake_t wake_kind;
  logic [ST_W-1:0] st_cnt;
  logic [DV_W-1:0] div_cnt;
  logic [PA_W-1:0] pa_hold;
  logic [IRQ_W-1:0] irq_block;
  logic [IRQ_W-1:0] irq_en_hold;
  logic stk_hold;

  // State decoding
  wire in_run = (state == WDHW_RUN);
  wire in_down = (state == WDHW_DOWN);
  wire in_start = (state == WDHW_START);
  wire in_idle = in_down && idle_select_bit;

  // APB decode; the slave always answers in the access cycle
  wire apb_acc = psel_i && penable_i;
  wire apb_wr = apb_acc && pwrite_i;
  wire hit_ctrl = (paddr_i == WDHW_CTRL_OFS);
  wire hit_wake = (paddr_i == WDHW_WAKE_OFS);
  wire hit_stat = (paddr_i == WDHW_STAT_OFS);
  wire hit_any = hit_ctrl || hit_wake || hit_stat;
  wire wr_ctrl = apb_wr && hit_ctrl;
  wire wr_wake = apb_wr && hit_wake;
  assign pready_o = 1'b1;
  assign pslverr_o = apb_acc && !hit_any;

  // Read mux, low bits only
  wire [31:0] rd_ctrl = {27'h0000000, idle_select_bit, pair_mode, src, dog_en};
  wire [31:0] rd_wake = 32'(wake_en);
  wire [31:0] rd_stat = {28'h0000000, in_start, in_down, tof, power_down_flag};
  wire [31:0] rd_mux = hit_ctrl ? rd_ctrl : hit_wake ? rd_wake : hit_stat ? rd_stat : 32'h00000000;
  assign prdata_o = rd_mux;

  // Instruction strobes count only while running; the clear strobes also need dog_en
  wire run_ok = in_run && !pin_rst;
  wire halt_ok = run_ok && halt_i;
  wire one_ok = run_ok && dog_en && !pair_mode && single_dog_clear_i;
  wire h1_ok = run_ok && dog_en && pair_mode && first_half_dog_clear_i;
  wire h2_ok = run_ok && dog_en && pair_mode && second_half_dog_clear_i;
  // Opposite half clears, a repeated half does nothing
  wire pair_clr = (h1_ok && last_half == WDHW_HALF_TWO) || (h2_ok && last_half == WDHW_HALF_ONE);
  wire sw_clr = one_ok || pair_clr;

  // Watchdog clock selection with power-down gating
  wire ins_edge = !in_down && (div_cnt == DV_LAST);
  wire rtc_tick = rtc_edge && !in_idle;
  wire sel_tick = (src == WDHW_SRC_OSC) ? osc_edge :
                  (src == WDHW_SRC_RTC) ? rtc_tick :
                  (src == WDHW_SRC_INS) ? ins_edge : 1'b0;

  wdhw_cnt_if cnt_bus();
  assign cnt_bus.clr = !dog_en || pin_rst || sw_clr || halt_ok;
  assign cnt_bus.tick = dog_en && sel_tick;
  wire tmo = cnt_bus.ovf && dog_en;

  wdhw_counter #(.PRE_W(PRE_W), .CNT_W(CNT_W)) u_counter (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .bus(cnt_bus)
  );

  // Wake sources while down
  wire [PA_W-1:0] pa_chg = (pa_s ^ pa_hold) & wake_en;
  wire pa_wake = in_down && (|pa_chg);
  wire [IRQ_W-1:0] irq_live = irq_req_i & ~irq_block;
  wire irq_wake = in_down && (|irq_live);
  wire irq_vec = |(irq_live & irq_en_hold) && !stk_hold;
  wire rst_wake = in_down && (pin_rst || tmo);
  wire any_wake = pa_wake || irq_wake || rst_wake;
  wire st_done = in_start && rtc_edge && (st_cnt == ST_LAST);

  // Clock and port control follow the power state
  assign sys_clk_en_o = !in_down;
  assign hold_ports_o = in_down;
  assign osc32k_en_o = !in_idle;
  assign power_down_flag_o = power_down_flag;
  assign timeout_flag_o = tof;

  // Oscillator edge history and instruction clock divider
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      osc_prev <= 1'b1;
      rtc_prev <= 1'b1;
      div_cnt <= '0;
    end else if (ce_i) begin
      osc_prev <= osc_s;
      rtc_prev <= rtc_s;
      div_cnt <= in_down ? div_cnt : div_cnt + 1'b1;
    end
  end

  // Software registers; the idle bit also falls on an idle wake
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      dog_en <= WDHW_EN_RST;
      src <= WDHW_SRC_OSC;
      pair_mode <= WDHW_PAIR_RST;
      idle_select_bit <= 1'b0;
      wake_en <= '0;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        dog_en <= pwdata_i[WDHW_CTRL_EN];
        src <= pwdata_i[WDHW_CTRL_SRC_LO +: 2];
        pair_mode <= pwdata_i[WDHW_CTRL_PAIR];
        idle_select_bit <= pwdata_i[WDHW_CTRL_IDLE];
      end else if (in_idle && any_wake) begin
        idle_select_bit <= 1'b0;
      end
      if (wr_wake) begin
        wake_en <= pwdata_i[PA_W-1:0];
      end
    end
  end

  // Paired clear memory
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      last_half <= WDHW_HALF_NONE;
    end else if (ce_i) begin
      if (pin_rst || !pair_mode) begin
        last_half <= WDHW_HALF_NONE;
      end else if (h1_ok) begin
        last_half <= WDHW_HALF_ONE;
      end else if (h2_ok) begin
        last_half <= WDHW_HALF_TWO;
      end
    end
  end

  // Status flags: time-out set wins over the halt clear
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      power_down_flag <= 1'b0;
      tof <= 1'b0;
    end else if (ce_i) begin
      if (pin_rst) begin
        power_down_flag <= 1'b0;
        tof <= 1'b0;
      end else if (tmo) begin
        tof <= 1'b1;
        power_down_flag <= in_down ? power_down_flag : 1'b0;
      end else if (halt_ok) begin
        power_down_flag <= 1'b1;
        tof <= 1'b0;
      end
    end
  end

  // Reset pulses: pin always resets the whole device; time-out resets the whole device unless down, PC and SP when down
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      device_reset_o <= 1'b0;
      pc_sp_reset_o <= 1'b0;
    end else if (ce_i) begin
      device_reset_o <= pin_rst || (tmo && !in_down);
      pc_sp_reset_o <= tmo && in_down && !pin_rst;
    end
  end

  // Power state machine
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state <= WDHW_RUN;
      wake_kind <= WDHW_WK_NONE;
      st_cnt <= '0;
      pa_hold <= '0;
      irq_block <= '0;
      irq_en_hold <= '0;
      stk_hold <= 1'b0;
    end else if (ce_i) begin
      case (state)
        WDHW_RUN: begin
          if (halt_ok) begin
            state <= WDHW_DOWN;
            pa_hold <= pa_s;
            irq_block <= irq_req_i;
          end
        end
        WDHW_DOWN: begin
          // Enables and stack depth are frozen with the core
          irq_en_hold <= irq_en_i;
          stk_hold <= stack_full_i;
          if (any_wake) begin
            state <= WDHW_START;
            st_cnt <= '0;
            if (rst_wake) begin
              wake_kind <= WDHW_WK_NONE;
            end else if (irq_wake && irq_vec) begin
              wake_kind <= WDHW_WK_IRQ;
            end else begin
              wake_kind <= WDHW_WK_NEXT;
            end
          end
        end
        WDHW_START: begin
          // Counts rising edges of the synchronised rtc_osc_i crystal, not system clocks
          if (pin_rst) begin
            state <= WDHW_RUN;
          end else if (st_done) begin
            state <= WDHW_RUN;
          end else if (rtc_edge) begin
            st_cnt <= st_cnt + 1'b1;
          end
        end
        default: begin
          state <= WDHW_RUN;
        end
      endcase
    end
  end

  // Resume strobes; vectoring may lag by the core's own cycles
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      resume_next_o <= 1'b0;
      irq_take_o <= 1'b0;
    end else if (ce_i) begin
      resume_next_o <= st_done && !pin_rst && wake_kind == WDHW_WK_NEXT;
      irq_take_o <= st_done && !pin_rst && wake_kind == WDHW_WK_IRQ;
    end
  end

  // Checks
  property p_halt_flags;
    @(posedge clock_i) disable iff (rst_i)
    ce_i && halt_ok && !tmo |=> power_down_flag && !tof && in_down;
  endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");

  property p_down_clk;
    @(posedge clock_i) disable iff (rst_i)
    in_down |-> !sys_clk_en_o && hold_ports_o;
  endproperty
  a_down_clk: assert property (p_down_clk) else $error("clock not stopped");

  property p_idle_osc;
    @(posedge clock_i) disable iff (rst_i)
    in_idle |-> !osc32k_en_o && !cnt_bus.tick || src == WDHW_SRC_OSC;
  endproperty
  a_idle_osc: assert property (p_idle_osc) else $error("idle oscillator running");

  property p_tmo_run;
    @(posedge clock_i) disable iff (rst_i)
    ce_i && tmo && in_run && !pin_rst |=> device_reset_o && tof;
  endproperty
  a_tmo_run: assert property (p_tmo_run) else $error("run timeout lost");

  property p_tmo_down;
    @(posedge clock_i) disable iff (rst_i)
    ce_i && tmo && in_down && !pin_rst |=> pc_sp_reset_o && !device_reset_o && in_start;
  endproperty
  a_tmo_down: assert property (p_tmo_down) else $error("sleep timeout wrong");

  property p_startup;
    @(posedge clock_i) disable iff (rst_i)
    (resume_next_o || irq_take_o) |-> $past(st_cnt) == ST_LAST && in_run;
  endproperty
  a_startup: assert property (p_startup) else $error("startup delay short");

  property p_idle_bit;
    @(posedge clock_i) disable iff (rst_i)
    ce_i && in_idle && any_wake && !wr_ctrl |=> !idle_select_bit;
  endproperty
  a_idle_bit: assert property (p_idle_bit) else $error("idle bit kept");

  property p_nop;
    @(posedge clock_i) disable iff (rst_i)
    !dog_en |-> !sw_clr && !tmo && !cnt_bus.tick;
  endproperty
  a_nop: assert property (p_nop) else $error("disabled watchdog active");

  property p_repeat;
    @(posedge clock_i) disable iff (rst_i)
    h1_ok && last_half == WDHW_HALF_ONE |-> !sw_clr;
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeated half cleared");

  property p_halt_clr;
    @(posedge clock_i) disable iff (rst_i)
    ce_i && halt_ok && dog_en |=> !tmo [*2];
  endproperty
  a_halt_clr: assert property (p_halt_clr) else $error("halt did not clear");
endmodule // wdhw_top

// File: inc/wdhw_pkg.sv
package wdhw_pkg;
  // APB register byte offsets
  localparam logic [7:0] WDHW_CTRL_OFS = 8'h00;
  localparam logic [7:0] WDHW_WAKE_OFS = 8'h04;
  localparam logic [7:0] WDHW_STAT_OFS = 8'h08;
  // CTRL fields
  localparam int WDHW_CTRL_EN = 0;
  localparam int WDHW_CTRL_SRC_LO = 1;
  localparam int WDHW_CTRL_PAIR = 3;
  localparam int WDHW_CTRL_IDLE = 4;
  // STATUS fields
  localparam int WDHW_STAT_PDF = 0;
  localparam int WDHW_STAT_TO = 1;
  localparam int WDHW_STAT_DOWN = 2;
  localparam int WDHW_STAT_START = 3;
  // Reset values
  localparam logic WDHW_EN_RST = 1'b1;
  localparam logic WDHW_PAIR_RST = 1'b0;
  // Watchdog clock sources
  typedef enum logic [1:0] {
    WDHW_SRC_OSC = 2'h0,
    WDHW_SRC_RTC = 2'h1,
    WDHW_SRC_INS = 2'h2
  } wdhw_src_t;
  // Paired clear memory
  typedef enum logic [1:0] {
    WDHW_HALF_NONE = 2'h0,
    WDHW_HALF_ONE = 2'h1,
    WDHW_HALF_TWO = 2'h2
  } wdhw_half_t;
  // Timing and widths
  localparam int WDHW_STARTUP_CYC = 1024;
  localparam int WDHW_INS_DIV = 4;
  localparam int WDHW_PORTA_W = 8;
  localparam int WDHW_IRQ_W = 4;
  localparam int WDHW_PRE_W = 8;
  localparam int WDHW_CNT_W = 8;
endpackage

// File: inc/wdhw_cnt_if.sv
`timescale 1ns/1ps
// Carries control and overflow between the controller and the counter
interface wdhw_cnt_if;
  logic clr;
  logic tick;
  logic ovf;
  modport ctl (output clr, output tick, input ovf);
  modport cnt (input clr, input tick, output ovf);
endinterface

// File: hdl/wdhw_counter.sv
`timescale 1ns/1ps
// Prescaler followed by the watchdog counter
module wdhw_counter #(
  parameter int PRE_W = 8,
  parameter int CNT_W = 8
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  wdhw_cnt_if.cnt bus
);
  // Widths below one leave no counter to overflow
  generate
    if (PRE_W < 1 || CNT_W < 1) begin : g_chk
      $error("wdhw_counter widths must be at least one");
    end
  endgenerate

  logic [PRE_W+CNT_W-1:0] count;
  wire all_ones = &count;

  // Overflow is the carry out of the joined prescaler and counter
  assign bus.ovf = bus.tick && all_ones && !bus.clr;

  // Clear beats tick so a clear instruction never loses to a count
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      count <= '0;
    end else if (ce_i) begin
      if (bus.clr) begin
        count <= '0;
      end else if (bus.tick) begin
        count <= count + 1'b1;
      end
    end
  end
endmodule // wdhw_counter

// File: verification/wdhw_osc_model.sv
`timescale 1ns/1ps
// Oscillators beside the core; periods are short so a 16-tick time-out on the watchdog oscillator takes about 128 cycles
module wdhw_osc_model #(
  parameter int OSC_HALF = 4,
  parameter int RTC_HALF = 2
) (
  input wire logic clock_i,
  input wire logic osc32k_en_i,
  output logic wdt_osc_o,
  output logic rtc_osc_o
);
  int osc_cnt = 0;
  int rtc_cnt = 0;
  initial wdt_osc_o = 1'b0;
  initial rtc_osc_o = 1'b0;
  // Internal watchdog oscillator runs free in every mode
  always @(posedge clock_i) begin
    osc_cnt <= (osc_cnt + 1) % OSC_HALF;
    if (osc_cnt == OSC_HALF - 1) wdt_osc_o <= ~wdt_osc_o;
  end
  // Crystal stands still whenever the block stops it, so idle really freezes its tick
  always @(posedge clock_i) begin
    if (osc32k_en_i === 1'b1) begin
      rtc_cnt <= (rtc_cnt + 1) % RTC_HALF;
      if (rtc_cnt == RTC_HALF - 1) rtc_osc_o <= ~rtc_osc_o;
    end
  end
endmodule // wdhw_osc_model

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top import wdhw_pkg::*; ;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] st = 4'h0;
  logic [3:0] irq_req = 4'h0;
  logic [3:0] irq_en = 4'h0;
  logic stack_full = 1'b0;
  logic pin_n = 1'b1;
  logic [7:0] porta = 8'h00;
  logic rst_seen = 1'b0;
  logic ce = 1'b1;
  wire logic [31:0] prdata;
  wire logic pready_o, pslverr_o, sys_clk_en, osc32k_en, hold_ports, device_reset_o;
  wire logic pc_sp_reset_o, resume_next_o, irq_take_o, power_down_flag, tof, wdt_osc, rtc_osc;
  int error_cnt = 0;
  int n_tests = 0;
  int seed = 32'h40395101;
  int c;
  logic [32:0] rq[$];
  logic [2:0] eq[$];

  always #10 clock_i = ~clock_i;

  // Short counter and prescaler so a time-out needs only 16 ticks
  wdhw_top #(.PRE_W(2), .CNT_W(2)) u_wdhw_top (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready_o), .pslverr_o(pslverr_o), .halt_i(st[3]),
    .single_dog_clear_i(st[0]), .first_half_dog_clear_i(st[1]), .second_half_dog_clear_i(st[2]),
    .irq_req_i(irq_req), .irq_en_i(irq_en), .stack_full_i(stack_full), .external_reset_pin_n_i(pin_n),
    .porta_i(porta), .wdt_osc_i(wdt_osc), .rtc_osc_i(rtc_osc), .sys_clk_en_o(sys_clk_en),
    .osc32k_en_o(osc32k_en), .hold_ports_o(hold_ports), .device_reset_o(device_reset_o),
    .pc_sp_reset_o(pc_sp_reset_o), .resume_next_o(resume_next_o), .irq_take_o(irq_take_o),
    .power_down_flag_o(power_down_flag), .timeout_flag_o(tof));

  wdhw_osc_model u_wdhw_osc_model (.clock_i(clock_i), .osc32k_en_i(osc32k_en), .wdt_osc_o(wdt_osc),
    .rtc_osc_o(rtc_osc));

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Monitor: reads and wake results are matched against the oldest note
  always @(posedge clock_i) begin
    if (psel && penable && pready_o && !pwrite) begin
      if (rq.size() == 0) check(33'h1FFFFFFFF, 33'h0);
      else check({pslverr_o, prdata}, rq.pop_front());
    end
    if (resume_next_o || irq_take_o || pc_sp_reset_o) begin
      if (eq.size() == 0) check(33'h1FFFFFFFF, 33'h0);
      else check({30'h0, irq_take_o, resume_next_o, pc_sp_reset_o}, {30'h0, eq.pop_front()});
    end
    if (device_reset_o === 1'b1) rst_seen <= 1'b1;
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (k == 20) begin
      error_cnt++;
      close_out();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // Strobe is dropped and one edge passes, so back-to-back calls never collide
  task automatic strobe(input logic [3:0] v);
    st <= v;
    @(posedge clock_i);
    st <= 4'h0;
    @(posedge clock_i);
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic wait_evt(input int n, output int k);
    k = 0;
    while (eq.size() != 0 && k < n) begin
      @(posedge clock_i);
      k++;
    end
    if (k == n) begin
      error_cnt++;
      close_out();
    end
  endtask

  initial begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(WDHW_CTRL_OFS, 33'h1);
    rd(WDHW_STAT_OFS, 33'h0);
    rd(8'h0C, 33'h100000000);
    $display("test reset values done");
    // Halt offered while the enable is low must leave the block running
    ce <= 1'b0;
    strobe(4'h8);
    ticks(1 + ($random(seed) & 7));
    check({32'h0, hold_ports}, 33'h0);
    ce <= 1'b1;
    ticks(2);
    $display("test clock enable done");
    repeat (10) begin
      strobe(4'h1);
      ticks(18 + ($random(seed) & 15));
    end
    check({32'h0, rst_seen}, 33'h0);
    ticks(300);
    check({32'h0, rst_seen}, 33'h1);
    rd(WDHW_STAT_OFS, 33'h2);
    apb(1'b1, WDHW_CTRL_OFS, 32'h0);
    ticks(4);
    rst_seen = 1'b0;
    strobe(4'h1);
    ticks(400);
    check({32'h0, rst_seen}, 33'h0);
    $display("test single clear and disable done");
    apb(1'b1, WDHW_CTRL_OFS, 32'h9);
    repeat (12) begin
      strobe(4'h2);
      ticks(18 + ($random(seed) & 15));
    end
    check({32'h0, rst_seen}, 33'h1);
    strobe(4'h2);
    strobe(4'h4);
    ticks(4);
    rst_seen = 1'b0;
    for (int i = 0; i < 12; i++) begin
      strobe(i[0] ? 4'h4 : 4'h2);
      ticks(18 + ($random(seed) & 15));
    end
    check({32'h0, rst_seen}, 33'h0);
    apb(1'b1, WDHW_CTRL_OFS, 32'h0);
    $display("test paired clear done");
    apb(1'b1, WDHW_WAKE_OFS, 32'h1);
    apb(1'b1, WDHW_CTRL_OFS, 32'h5);
    strobe(4'h1);
    strobe(4'h8);
    rd(WDHW_STAT_OFS, 33'h5);
    check({30'h0, sys_clk_en, hold_ports, osc32k_en}, 33'h3);
    rst_seen = 1'b0;
    ticks(300);
    check({32'h0, rst_seen}, 33'h0);
    apb(1'b1, WDHW_CTRL_OFS, 32'h0);
    porta <= 8'h02 | (8'($random(seed)) & 8'hFC);
    ticks(100);
    rd(WDHW_STAT_OFS, 33'h5);
    eq.push_back(3'b010);
    porta[0] <= 1'b1;
    wait_evt(6000, c);
    check({32'h0, (c >= 4 * WDHW_STARTUP_CYC - 8 && c <= 4 * WDHW_STARTUP_CYC + 44)}, 33'h1);
    rd(WDHW_STAT_OFS, 33'h1);
    $display("test halt and port wake done");
    irq_en <= 4'h2;
    irq_req <= 4'h1;
    for (int i = 0; i < 2; i++) begin
      stack_full <= i[0];
      strobe(4'h8);
      ticks(300);
      eq.push_back(i[0] ? 3'b010 : 3'b100);
      irq_req <= 4'h3;
      wait_evt(6000, c);
      irq_req <= 4'h1;
      ticks(2);
    end
    $display("test interrupt wake done");
    apb(1'b1, WDHW_CTRL_OFS, 32'h13);
    strobe(4'h1);
    strobe(4'h8);
    check({32'h0, osc32k_en}, 33'h0);
    rst_seen = 1'b0;
    ticks(300);
    check({32'h0, rst_seen}, 33'h0);
    apb(1'b1, WDHW_CTRL_OFS, 32'h10);
    eq.push_back(3'b010);
    porta[0] <= 1'b0;
    wait_evt(6000, c);
    rd(WDHW_CTRL_OFS, 33'h0);
    $display("test idle done");
    apb(1'b1, WDHW_CTRL_OFS, 32'h1);
    strobe(4'h1);
    ticks(80);
    strobe(4'h8);
    eq.push_back(3'b001);
    wait_evt(1000, c);
    check({32'h0, (c >= 100 && c <= 160)}, 33'h1);
    rd(WDHW_STAT_OFS, 33'hB);
    apb(1'b1, WDHW_CTRL_OFS, 32'h0);
    ticks(4400);
    $display("test time-out while down done");
    strobe(4'h8);
    rst_seen = 1'b0;
    pin_n <= 1'b0;
    ticks(10);
    check({32'h0, rst_seen}, 33'h1);
    pin_n <= 1'b1;
    ticks(6);
    rd(WDHW_STAT_OFS, 33'h0);
    $display("test pin reset done");
    close_out();
  end
endmodule // tb_top
